// ### iopt_defines.svh
`ifndef IOPT_DEFINES_SVH
`define IOPT_DEFINES_SVH

// Register word indices on the Avalon address
`define IOPT_REG_TRIM       2'h0
`define IOPT_REG_CTRL       2'h1
`define IOPT_REG_GPIO       2'h2
`define IOPT_REG_STATUS     2'h3

// Trim register fields
`define IOPT_TRIM_LSB       0
`define IOPT_TRIM_MSB       5
`define IOPT_MULT_EN_BIT    6
`define IOPT_TRIM_RESET     6'h00
`define IOPT_MULT_EN_RESET  1'b0

// Control register fields
`define IOPT_FSEL_LSB       4
`define IOPT_FSEL_MSB       6
`define IOPT_MODE_BIT       0
`define IOPT_FSEL_RESET     3'h7
`define IOPT_MODE_RESET     1'b0

// Frequency select codes
`define IOPT_FSEL_16M       3'h7
`define IOPT_FSEL_8M        3'h6
`define IOPT_FSEL_4M        3'h5
`define IOPT_FSEL_2M        3'h4
`define IOPT_FSEL_1M        3'h3
`define IOPT_FSEL_500K      3'h2
`define IOPT_FSEL_250K      3'h1

// Frequencies in kHz
`define IOPT_KHZ_16M        17'h03e80
`define IOPT_KHZ_8M         17'h01f40
`define IOPT_KHZ_4M         17'h00fa0
`define IOPT_KHZ_2M         17'h007d0
`define IOPT_KHZ_1M         17'h003e8
`define IOPT_KHZ_500K       17'h001f4
`define IOPT_KHZ_250K       17'h000fa
`define IOPT_KHZ_LF         17'h0001f
`define IOPT_MULT_SHIFT     2

// GPIO register fields
`define IOPT_GPIO_OUT_LSB   0
`define IOPT_GPIO_DIR_LSB   4
`define IOPT_GPIO_IN_LSB    8
`define IOPT_GPIO_RESET     2'h0

// Status register fields
`define IOPT_STAT_MULT_BIT  8

// Timing
`define IOPT_CLK_PERIOD_NS  4
`define IOPT_SETTLE_STEP_NS 1000
`define IOPT_SETTLE_CYC     (`IOPT_SETTLE_STEP_NS / `IOPT_CLK_PERIOD_NS)

`endif

// ### iopt_pkg.sv
package iopt_pkg;

  localparam int IOPT_CNT_W = 12;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [1:0]  address;
    logic [31:0] writedata;
  } iopt_av_req_t;

  typedef struct packed {
    logic                  one_out;
    logic                  one_oe;
    logic                  two_out;
    logic                  two_oe;
  } iopt_pins_t;

  typedef struct packed {
    logic [5:0]            trim_target;
    logic                  pll_en;
    logic [2:0]            fsel;
    logic                  mode_io;
    logic [1:0]            io_out;
    logic [1:0]            io_dir;
    logic [5:0]            trim_eff;
    logic [IOPT_CNT_W-1:0] step_cnt;
    logic [1:0]            div_cnt;
    logic [1:0]            s1;
    logic [1:0]            s2;
    logic [1:0]            s3;
    logic [1:0]            io_in;
    logic                  waitreq;
    logic [31:0]           rdata;
    logic [16:0]           sysclk_khz;
    logic [16:0]           lf_khz;
    logic                  mult_on;
    iopt_pins_t            pins;
  } iopt_state_t;

endpackage

// ### iopt_ctrl.sv
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "iopt_defines.svh"
// Overview of operation
// - Enabled multiplier gives four times the oscillator, 32 or 64 MHz.
// - Trim register bit 6 enables or disables the multiplier.
// - Multiplier works only with frequency select codes 111 or 110.
// - Clock-out mode drives Fosc/4 on pin two; pin one is port bit 7.
// - Two-io mode: pin one is port bit 7, pin two is port bit 6.
// - Default trim gives nominal 16 MHz oscillator output.
// - Six-bit trim field in bits 5:0 adjusts oscillator frequency.
// - After a trim write, high and mid oscillators step gradually to it.
// - No flag shows the settling has finished; operation continues.
// - Low-frequency oscillator is independent and ignores trim.
module iopt_ctrl
  import iopt_pkg::*;
#(
  parameter int SETTLE_STEP_CYC = `IOPT_SETTLE_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire iopt_av_req_t av_req,
  output logic              av_waitrequest,
  output logic [31:0]       av_readdata,
  input  wire logic         osc_pin_one_in,
  input  wire logic         osc_pin_two_in,
  output logic              osc_pin_one_out,
  output logic              osc_pin_one_oe,
  output logic              osc_pin_two_out,
  output logic              osc_pin_two_oe,
  output logic [16:0]       sysclk_khz,
  output logic              mult_active,
  output logic [5:0]        high_freq_trim,
  output logic [5:0]        mid_freq_trim,
  output logic [16:0]       low_freq_khz
);

  localparam logic [IOPT_CNT_W-1:0] STEP_LAST = IOPT_CNT_W'(SETTLE_STEP_CYC - 1);

  iopt_state_t q;
  iopt_state_t n;

  function automatic logic [16:0] base_khz(input logic [2:0] fsel);
    case (fsel)
      `IOPT_FSEL_16M:  base_khz = `IOPT_KHZ_16M;
      `IOPT_FSEL_8M:   base_khz = `IOPT_KHZ_8M;
      `IOPT_FSEL_4M:   base_khz = `IOPT_KHZ_4M;
      `IOPT_FSEL_2M:   base_khz = `IOPT_KHZ_2M;
      `IOPT_FSEL_1M:   base_khz = `IOPT_KHZ_1M;
      `IOPT_FSEL_500K: base_khz = `IOPT_KHZ_500K;
      `IOPT_FSEL_250K: base_khz = `IOPT_KHZ_250K;
      default:         base_khz = `IOPT_KHZ_LF;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input iopt_state_t s, input logic [1:0] addr);
    read_mux = 32'h0000_0000;
    case (addr)
      `IOPT_REG_TRIM: begin
        read_mux[`IOPT_TRIM_MSB:`IOPT_TRIM_LSB] = s.trim_target;
        read_mux[`IOPT_MULT_EN_BIT]             = s.pll_en;
      end
      `IOPT_REG_CTRL: begin
        read_mux[`IOPT_FSEL_MSB:`IOPT_FSEL_LSB] = s.fsel;
        read_mux[`IOPT_MODE_BIT]                = s.mode_io;
      end
      `IOPT_REG_GPIO: begin
        read_mux[`IOPT_GPIO_OUT_LSB+:2] = s.io_out;
        read_mux[`IOPT_GPIO_DIR_LSB+:2] = s.io_dir;
        read_mux[`IOPT_GPIO_IN_LSB+:2]  = s.io_in;
      end
      default: begin
        read_mux[5:0]                 = s.trim_eff;
        read_mux[`IOPT_STAT_MULT_BIT] = s.mult_on;
      end
    endcase
  endfunction

  always_comb begin
    n = q;
    n.div_cnt = q.div_cnt + 2'h1;

    // Three-stage sync; a change counts once stages two and three agree
    n.s1 = {osc_pin_one_in, osc_pin_two_in};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.io_in = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.io_in);

    // one trim step per settle interval, never a jump
    if (q.trim_eff != q.trim_target) begin
      if (q.step_cnt >= STEP_LAST) begin
        n.step_cnt = '0;
        if ($signed(q.trim_target) > $signed(q.trim_eff)) begin
          n.trim_eff = q.trim_eff + 6'h01;
        end else begin
          n.trim_eff = q.trim_eff - 6'h01;
        end
      end else begin
        n.step_cnt = q.step_cnt + IOPT_CNT_W'(1);
      end
    end else begin
      n.step_cnt = '0;
    end

    // only the 16 and 8 MHz selects may be multiplied
    n.mult_on = q.pll_en && (q.fsel == `IOPT_FSEL_16M || q.fsel == `IOPT_FSEL_8M);
    // four times the base; base alone otherwise
    n.sysclk_khz = n.mult_on ? (base_khz(q.fsel) << `IOPT_MULT_SHIFT) : base_khz(q.fsel);
    // low-frequency source never sees the trim
    n.lf_khz = `IOPT_KHZ_LF;

    // pin one is port bit 7 in both modes
    n.pins.one_oe  = q.io_dir[1];
    n.pins.one_out = q.io_out[1];
    if (q.mode_io) begin
      // pin two is port bit 6
      n.pins.two_oe  = q.io_dir[0];
      n.pins.two_out = q.io_out[0];
    end else begin
      n.pins.two_oe  = 1'b1;
      n.pins.two_out = q.div_cnt[1];
    end

    // One wait cycle; write lands on the edge that sees waitrequest low
    if (q.waitreq) begin
      if (av_req.read || av_req.write) begin
        n.waitreq = 1'b0;
        n.rdata   = read_mux(q, av_req.address);
      end
    end else begin
      n.waitreq = 1'b1;
      if (av_req.write) begin
        case (av_req.address)
          `IOPT_REG_TRIM: begin
            n.trim_target = av_req.writedata[`IOPT_TRIM_MSB:`IOPT_TRIM_LSB];
            n.pll_en      = av_req.writedata[`IOPT_MULT_EN_BIT];
          end
          `IOPT_REG_CTRL: begin
            n.fsel    = av_req.writedata[`IOPT_FSEL_MSB:`IOPT_FSEL_LSB];
            n.mode_io = av_req.writedata[`IOPT_MODE_BIT];
          end
          `IOPT_REG_GPIO: begin
            n.io_out = av_req.writedata[`IOPT_GPIO_OUT_LSB+:2];
            n.io_dir = av_req.writedata[`IOPT_GPIO_DIR_LSB+:2];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q             <= '0;
      q.trim_target <= `IOPT_TRIM_RESET;
      q.trim_eff    <= `IOPT_TRIM_RESET;
      q.pll_en      <= `IOPT_MULT_EN_RESET;
      q.fsel        <= `IOPT_FSEL_RESET;
      q.mode_io     <= `IOPT_MODE_RESET;
      q.io_out      <= `IOPT_GPIO_RESET;
      q.io_dir      <= `IOPT_GPIO_RESET;
      q.waitreq     <= 1'b1;
      q.sysclk_khz  <= `IOPT_KHZ_16M;
      q.lf_khz      <= `IOPT_KHZ_LF;
    end else begin
      q <= n;
    end
  end

  assign av_waitrequest  = q.waitreq;
  assign av_readdata     = q.rdata;
  assign osc_pin_one_out = q.pins.one_out;
  assign osc_pin_one_oe  = q.pins.one_oe;
  assign osc_pin_two_out = q.pins.two_out;
  assign osc_pin_two_oe  = q.pins.two_oe;
  assign sysclk_khz      = q.sysclk_khz;
  assign mult_active     = q.mult_on;
  assign high_freq_trim  = q.trim_eff;
  assign mid_freq_trim   = q.trim_eff;
  assign low_freq_khz    = q.lf_khz;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence trim_write_s;
    !q.waitreq && av_req.write && av_req.address == `IOPT_REG_TRIM;
  endsequence

  sequence eff_step_s;
    q.trim_eff != $past(q.trim_eff);
  endsequence

  a_mult_sixteen: assert property (
    q.pll_en && q.fsel == `IOPT_FSEL_16M |=> sysclk_khz == 17'h0fa00 && mult_active)
    else $error("16 MHz select with multiplier did not give 64 MHz");

  a_mult_eight: assert property (
    q.pll_en && q.fsel == `IOPT_FSEL_8M |=> sysclk_khz == 17'h07d00)
    else $error("8 MHz select with multiplier did not give 32 MHz");

  a_bad_select: assert property (
    q.pll_en && q.fsel == `IOPT_FSEL_4M |=> sysclk_khz == `IOPT_KHZ_4M && !mult_active)
    else $error("Multiplier applied to a forbidden select");

  a_enable_bit: assert property (
    trim_write_s |=> q.pll_en == $past(av_req.writedata[`IOPT_MULT_EN_BIT]) ##2 mult_active ==
      (q.pll_en && q.fsel[2:1] == 2'h3))
    else $error("Multiplier enable did not follow bit 6");

  a_trim_write: assert property (
    trim_write_s |=> q.trim_target == $past(av_req.writedata[5:0]))
    else $error("Trim field not stored");

  a_settle_gradual: assert property (
    eff_step_s |=> q.trim_eff == $past(q.trim_eff) [*1] ##0
      (q.trim_eff - $past(q.trim_eff, 2) == 6'h01 || $past(q.trim_eff, 2) - q.trim_eff == 6'h01))
    else $error("Trim moved by more than one step");

  a_nominal_freq: assert property (
    !q.pll_en && q.fsel == `IOPT_FSEL_16M |=> sysclk_khz == `IOPT_KHZ_16M)
    else $error("Nominal output is not 16 MHz");

  a_lf_fixed: assert property (
    trim_write_s |-> ##[1:3] low_freq_khz == `IOPT_KHZ_LF)
    else $error("Low-frequency source changed with trim");

  a_clkout_pin: assert property (
    !q.mode_io [*2] |=> osc_pin_two_oe && osc_pin_two_out == $past(q.div_cnt[1]))
    else $error("Pin two not driving Fosc/4");

  a_two_io_pin: assert property (
    q.mode_io |=> osc_pin_two_oe == $past(q.io_dir[0]) && osc_pin_one_oe == $past(q.io_dir[1]))
    else $error("Pins not following port bits 6 and 7");

  a_wait_once: assert property (
    (av_req.read || av_req.write) && q.waitreq |=> !av_waitrequest ##1 av_waitrequest)
    else $error("Wait cycle not exactly one");

  sequence step_due_s;
    q.trim_eff != q.trim_target && q.step_cnt >= STEP_LAST;
  endsequence

  a_pin_one_drive: assert property (
    q.io_dir[1] |=> osc_pin_one_oe && osc_pin_one_out == $past(q.io_out[1]))
    else $error("Pin one not driving port bit 7");

  a_pin_one_float: assert property (
    !q.io_dir[1] |=> !osc_pin_one_oe)
    else $error("Pin one driven while port bit 7 is an input");

  // Four settled cycles first, so reset values do not look like a stuck clock
  a_clkout_period: assert property (
    !q.mode_io [*4] |=> osc_pin_two_out != $past(osc_pin_two_out, 2))
    else $error("Pin two clock out has the wrong period");

  a_sync_agree: assert property (
    q.s2 == q.s3 |=> q.io_in == $past(q.s3))
    else $error("Synced input ignored agreeing stages");

  a_sync_hold: assert property (
    q.s2[0] != q.s3[0] |=> q.io_in[0] == $past(q.io_in[0]))
    else $error("Synced input took a disagreeing stage");

  a_trim_no_jump: assert property (
    trim_write_s ##0 q.trim_eff == q.trim_target |=>
      ##1 high_freq_trim == $past(high_freq_trim, 2))
    else $error("Trim jumped at the write");

  a_eff_idle: assert property (
    q.trim_eff == q.trim_target |=> $stable(high_freq_trim))
    else $error("Effective trim moved with no pending target");

  a_step_hold: assert property (
    q.trim_eff != q.trim_target && q.step_cnt < STEP_LAST |=> $stable(high_freq_trim))
    else $error("Trim stepped before the settle interval ended");

  a_step_up: assert property (
    step_due_s ##0 $signed(q.trim_target) > $signed(q.trim_eff) |=>
      high_freq_trim == $past(q.trim_eff) + 6'h01)
    else $error("Trim did not step up toward the target");

  a_step_down: assert property (
    step_due_s ##0 $signed(q.trim_target) < $signed(q.trim_eff) |=>
      high_freq_trim == $past(q.trim_eff) - 6'h01)
    else $error("Trim did not step down toward the target");

  a_status_read: assert property (
    q.waitreq && av_req.read && av_req.address == `IOPT_REG_STATUS |=>
      av_readdata[5:0] == $past(q.trim_eff) && av_readdata[8] == $past(q.mult_on) &&
      av_readdata[31:9] == 23'h000000 && av_readdata[7:6] == 2'h0)
    else $error("Status word carries more than trim and multiplier state");

  a_rdata_hold: assert property (
    q.waitreq && !av_req.read && !av_req.write |=> $stable(av_readdata))
    else $error("Read data changed with no request");

  a_status_ro: assert property (
    !q.waitreq && av_req.write && av_req.address == `IOPT_REG_STATUS |=>
      $stable(q.trim_target) && $stable(q.pll_en) && $stable(q.fsel) && $stable(q.mode_io))
    else $error("Status write changed a register");

  a_ctrl_write: assert property (
    !q.waitreq && av_req.write && av_req.address == `IOPT_REG_CTRL |=>
      q.fsel == $past(av_req.writedata[`IOPT_FSEL_MSB:`IOPT_FSEL_LSB]) &&
      q.mode_io == $past(av_req.writedata[`IOPT_MODE_BIT]))
    else $error("Control register not stored");

  a_enable_clear: assert property (
    trim_write_s ##0 !av_req.writedata[`IOPT_MULT_EN_BIT] |=> ##1 !mult_active)
    else $error("Multiplier stayed on after enable was cleared");

endmodule

// ### iopt_ctrl_tb.sv
`timescale 1ns/1ps
module iopt_ctrl_tb;
  import iopt_pkg::*;

  logic         core_clk = 1'b0;
  logic         rstn     = 1'b0;
  iopt_av_req_t av_req   = '0;
  logic         pin1_in  = 1'b0;
  logic         pin2_in  = 1'b1;
  logic         av_waitrequest;
  logic [31:0]  av_readdata;
  logic         osc_pin_one_out;
  logic         osc_pin_one_oe;
  logic         osc_pin_two_out;
  logic         osc_pin_two_oe;
  logic [16:0]  sysclk_khz;
  logic         mult_active;
  logic [5:0]   high_freq_trim;
  logic [5:0]   mid_freq_trim;
  logic [16:0]  low_freq_khz;
  int           fail_count = 0;
  int           num_checks = 0;
  int           cycles     = 0;
  int           tg;
  logic         prev;
  logic [31:0]  rd;
  logic [16:0]  khz [8] = '{17'h0001f, 17'h000fa, 17'h001f4, 17'h003e8,
                           17'h007d0, 17'h00fa0, 17'h01f40, 17'h03e80};

  always #2 core_clk = ~core_clk;

  iopt_ctrl #(.SETTLE_STEP_CYC(4)) u_dut (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .av_req         (av_req),
    .av_waitrequest (av_waitrequest),
    .av_readdata    (av_readdata),
    .osc_pin_one_in (pin1_in),
    .osc_pin_two_in (pin2_in),
    .osc_pin_one_out(osc_pin_one_out),
    .osc_pin_one_oe (osc_pin_one_oe),
    .osc_pin_two_out(osc_pin_two_out),
    .osc_pin_two_oe (osc_pin_two_oe),
    .sysclk_khz     (sysclk_khz),
    .mult_active    (mult_active),
    .high_freq_trim (high_freq_trim),
    .mid_freq_trim  (mid_freq_trim),
    .low_freq_khz   (low_freq_khz)
  );

  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Values seen right after the edge are still the pre-edge flop values
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    av_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge core_clk);
    end while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_req <= '0;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 2'h0, 32'h0);
    chk(rd, 32'h00000000);
    bus(1'b0, 2'h1, 32'h0);
    chk(rd, 32'h00000070);
    chk(sysclk_khz, 32'h00003e80);
    chk(osc_pin_two_oe, 1'b1);
    // Bit 7 is not implemented
    bus(1'b1, 2'h0, 32'h000000ff);
    bus(1'b0, 2'h0, 32'h0);
    chk(rd, 32'h0000007f);
    bus(1'b1, 2'h0, 32'h00000040);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 2'h1, {25'h0, 3'(c), 4'h0});
      repeat (3) @(posedge core_clk);
      chk(mult_active, (c >= 6));
      chk(sysclk_khz, (c >= 6) ? {khz[c], 2'b00} : khz[c]);
      bus(1'b0, 2'h3, 32'h0);
      chk(rd[8], (c >= 6));
    end
    bus(1'b1, 2'h0, 32'h00000000);
    repeat (3) @(posedge core_clk);
    chk(mult_active, 1'b0);
    chk(sysclk_khz, 32'h00003e80);
    bus(1'b1, 2'h0, 32'h00000005);
    repeat (2) @(posedge core_clk);
    chk(high_freq_trim < 6'h05, 1'b1);
    repeat (10) @(posedge core_clk);
    chk(high_freq_trim > 6'h00 && high_freq_trim < 6'h05, 1'b1);
    repeat (40) @(posedge core_clk);
    chk(high_freq_trim, 32'h05);
    chk(mid_freq_trim, 32'h05);
    chk(low_freq_khz, 32'h0000001f);
    chk(sysclk_khz, 32'h00003e80);
    bus(1'b1, 2'h3, 32'hffffffff);
    bus(1'b0, 2'h3, 32'h0);
    chk(rd, 32'h00000005);
    // clock out toggles on pin two
    tg = 0;
    prev = osc_pin_two_out;
    repeat (16) begin
      @(posedge core_clk);
      if (osc_pin_two_out !== prev) tg++;
      prev = osc_pin_two_out;
    end
    chk(tg >= 4, 1'b1);
    bus(1'b1, 2'h2, 32'h00000033);
    repeat (3) @(posedge core_clk);
    chk({osc_pin_one_oe, osc_pin_one_out, osc_pin_two_oe}, 3'b111);
    bus(1'b1, 2'h1, 32'h00000071);
    repeat (3) @(posedge core_clk);
    chk({osc_pin_two_oe, osc_pin_two_out}, 2'b11);
    bus(1'b1, 2'h2, 32'h00000001);
    pin1_in <= 1'b1;
    pin2_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({osc_pin_one_oe, osc_pin_two_oe}, 2'b00);
    bus(1'b0, 2'h2, 32'h0);
    chk(rd[9:8], 2'b10);
    wrap_up();
  end
endmodule
